// *** rtl/mpc_pkg.sv ***
// Purpose: Shared constants and types of the multiphase PWM control block.
// Assumes: A 10 MHz system clock.
// Notes: Frequencies are in hertz, counts in system clock cycles.
package mpc_pkg;
	// Clock and switching frequency figures.
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned PRESET_HZ = 300_000;
	localparam int unsigned RES_HZ_PER_KOHM = 6_000; // 600 kHz per 100 kohm.
	localparam int unsigned MIN_HZ = 120_000;
	localparam int unsigned MAX_HZ = 1_000_000;
	localparam int unsigned EXT_CLK_MULT = 4;
	localparam logic [15:0] PRESET_QUARTER =
		16'(CLK_HZ / (EXT_CLK_MULT * PRESET_HZ));
	// Overvoltage must persist this many clock cycles before it trips.
	localparam logic [7:0] OVP_CYCLES = 8'h80;
	// Strap settling time after reset, in cycles.
	localparam logic [3:0] INIT_CYCLES = 4'hf;
	// Frequency pin modes reported by the pin detector.
	localparam logic [1:0] FREQ_OPEN = 2'h0;
	localparam logic [1:0] FREQ_RES = 2'h1;
	localparam logic [1:0] FREQ_EXT = 2'h2;
	// Quarter indices of the switching period.
	localparam logic [1:0] Q_MASTER_A = 2'h0;
	localparam logic [1:0] Q_SLAVE_A = 2'h1;
	localparam logic [1:0] Q_MASTER_B = 2'h2;
	localparam logic [1:0] Q_SLAVE_B = 2'h3;
	// Register offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DUTY = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	localparam logic [7:0] REG_QUARTER = 8'h14;
	// Control register fields and reset values.
	localparam int CTRL_SLAVE = 0;
	localparam logic [15:0] DUTY_RESET = 16'h0010;
	// Interrupt status bit positions.
	localparam int IRQ_THERMAL = 0;
	localparam int IRQ_OVP = 1;
	localparam int IRQ_RESTART = 2;
	localparam int IRQ_STRAP = 3;
	localparam int IRQ_W = 4;
	// Gate sequencing states.
	typedef enum logic [3:0] {
		GATE_IDLE = 4'h1,
		GATE_LOW = 4'h2,
		GATE_WAIT = 4'h4,
		GATE_HIGH = 4'h8
	} mpc_gate_t;
endpackage

// *** rtl/mpc_sync.sv ***
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module mpc_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// Asynchronous levels in, clean levels out.
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// Two stages give metastability time to settle.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// *** rtl/mpc_gate_guard.sv ***
// Purpose: Low and high side command sequencing for one phase.
// Assumes: The low gate feedback is already synchronised.
// Notes: The high side waits for the low gate to be seen off.
`timescale 1ns/1ns
module mpc_gate_guard import mpc_pkg::*; (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// Control.
	input wire logic enable_in,
	input wire logic start_in,
	input wire logic [15:0] duty_in,
	input wire logic low_gate_feedback_in,
	// Driver commands.
	output logic low_cmd_out,
	output logic high_cmd_out
);
	mpc_gate_t state;
	logic pend;
	logic [15:0] on_cnt;

	// Turning the high side off costs one idle cycle before the low side.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in || !enable_in) begin
			state <= GATE_IDLE;
			pend <= 1'b0;
			on_cnt <= 16'h0000;
		end else begin
			case (state)
				GATE_IDLE: begin
					if (start_in || pend) begin
						state <= GATE_LOW;
						pend <= 1'b0;
						on_cnt <= 16'h0000;
					end
				end
				GATE_LOW: begin
					on_cnt <= on_cnt + 16'h0001;
					if (on_cnt >= duty_in || start_in)
						state <= GATE_WAIT;
				end
				GATE_WAIT: begin
					if (start_in)
						pend <= 1'b1;
					if (!low_gate_feedback_in)
						state <= GATE_HIGH;
				end
				GATE_HIGH: begin
					if (start_in) begin
						state <= GATE_IDLE;
						pend <= 1'b1;
					end
				end
				default: state <= GATE_IDLE;
			endcase
		end
	end

	// Commands come straight from state flip-flops.
	assign low_cmd_out = (state == GATE_LOW);
	assign high_cmd_out = (state == GATE_HIGH);

	property p_high_after_low;
		@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(high_cmd_out) |-> $past(!low_gate_feedback_in);
	endproperty
	a_high_after_low: assert property (p_high_after_low)
		else $error("high side raised while low gate was on");

	property p_no_overlap;
		@(posedge mclk_in) disable iff (!reset_n_in)
		!(low_cmd_out && high_cmd_out);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("low and high commands overlap");
endmodule

// *** rtl/mpc_ctrl.sv ***
// Purpose: Strap decode, fault sequencing and phase timing of a
//   multiphase boost controller with a small register port.
// Assumes: Analog comparators and the strap ADC deliver pin levels.
// Notes: Pin levels pass two flip-flops before any logic reads them.
`timescale 1ns/1ns
// How it works
// - Overvoltage off: power good holds while feedback exceeds reference.
// - One strap selects overvoltage, level shifter and phase grouping.
// - Thermal trip raises a fault, stops drivers, discharges soft-start.
// - Thermal fault holds until cooled by hysteresis, then restarts.
// - Open frequency pin selects the 300 kHz preset.
// - External clock runs at four times switching rate; period derived.
// - Resistor sets 6 kHz per kohm, clamped to 120 kHz..1 MHz.
// - Strap phase count decides the response to the sync signal.
// - The two phases of one chip start half a period apart.
// - Slave phases lag master phases by a quarter period.
// - Strap codes 0..3 are multiphase with table settings.
// - Strap codes 4..7 are single phase with table settings.
// - One chip serves one or two phases; four need two.
// - Low gate feedback is watched to block shoot-through.
// - Overvoltage over 128 cycles drops power good and restarts on clear.
// - Any fault pulls every driver output low at once.
module mpc_ctrl import mpc_pkg::*; #(
	parameter int PHASES = 2,
	parameter int DUTY_W = 16
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// Register port.
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	output logic irq_out,
	// Strap and frequency pin detection.
	input wire logic [2:0] overvoltage_strap_in,
	input wire logic [1:0] frequency_set_pin_mode_in,
	input wire logic frequency_set_pin_clk_in,
	input wire logic [7:0] frequency_set_pin_kohm_in,
	// Analog comparator results.
	input wire logic feedback_sense_over_ref_in,
	input wire logic feedback_sense_ovp_in,
	input wire logic soft_start_above_1v_in,
	input wire logic soft_start_above_50mv_in,
	input wire logic thermal_trip_in,
	input wire logic thermal_cooled_in,
	// Multiphase sync and gate feedback.
	input wire logic sync_in,
	output logic sync_out,
	input wire logic [PHASES-1:0] low_gate_feedback_in,
	// Drivers and status pins.
	output logic [PHASES-1:0] low_drive_out,
	output logic [PHASES-1:0] high_drive_out,
	output logic soft_start_discharge_out,
	output logic power_good_flag_out,
	output logic level_shift_enable_out,
	output logic thermal_fault_out
);
	logic [2:0] strap_s;
	logic [1:0] fmode_s;
	logic [7:0] kohm_s;
	logic fclk_s, fclk_d, sync_s, sync_d;
	logic fb_ref_s, fb_ovp_s, ss1_s, ss50_s, trip_s, cool_s;
	logic [PHASES-1:0] lfb_s;
	logic [3:0] init_cnt;
	logic init_done, multi_phase, ovp_on;
	logic thermal_fault, ovp_fault;
	logic [7:0] ovp_cnt;
	logic slave;
	logic [DUTY_W-1:0] duty;
	logic [15:0] quarter, next_quarter, q_cnt;
	logic [1:0] q_idx;
	logic q_tick, any_fault, run_en;
	logic [PHASES-1:0] ph_start, low_cmd, high_cmd;
	logic [IRQ_W-1:0] irq_stat, irq_mask, irq_ev;
	logic thermal_d, ovp_d;

	// Strap table: bit2 multiphase, bit1 overvoltage on, bit0 shifter on.
	function automatic logic [2:0] strap_decode(input logic [2:0] code);
		case (code)
			3'h0: strap_decode = 3'h6;
			3'h1: strap_decode = 3'h5;
			3'h2: strap_decode = 3'h7;
			3'h3: strap_decode = 3'h4;
			3'h4: strap_decode = 3'h1;
			3'h5: strap_decode = 3'h3;
			3'h6: strap_decode = 3'h0;
			default: strap_decode = 3'h2;
		endcase
	endfunction

	// Quarter period in cycles for a switching frequency in hertz.
	function automatic logic [15:0] quarter_of(input int unsigned hz);
		int unsigned f;
		f = hz;
		if (f < MIN_HZ)
			f = MIN_HZ;
		if (f > MAX_HZ)
			f = MAX_HZ;
		quarter_of = 16'(CLK_HZ / (EXT_CLK_MULT * f));
	endfunction

	// Pin levels cross into the clock domain.
	mpc_sync #(.W(21)) u_sync_pins (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.async_in({overvoltage_strap_in, frequency_set_pin_mode_in,
			frequency_set_pin_kohm_in, frequency_set_pin_clk_in,
			sync_in, feedback_sense_over_ref_in, feedback_sense_ovp_in,
			soft_start_above_1v_in, soft_start_above_50mv_in,
			thermal_trip_in, thermal_cooled_in}),
		.sync_out({strap_s, fmode_s, kohm_s, fclk_s, sync_s, fb_ref_s,
			fb_ovp_s, ss1_s, ss50_s, trip_s, cool_s})
	);

	mpc_sync #(.W(PHASES)) u_sync_gate (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.async_in(low_gate_feedback_in),
		.sync_out(lfb_s)
	);

	// Edge history of the clean clock and sync levels.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			fclk_d <= 1'b0;
			sync_d <= 1'b0;
		end else begin
			fclk_d <= fclk_s;
			sync_d <= sync_s;
		end
	end

	// strap captured once
	// The strap is read after a short settle so the divider has charged.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			init_cnt <= 4'h0;
			init_done <= 1'b0;
			multi_phase <= 1'b0;
			ovp_on <= 1'b0;
			level_shift_enable_out <= 1'b0;
		end else if (!init_done) begin
			init_cnt <= init_cnt + 4'h1;
			if (init_cnt == INIT_CYCLES) begin
				init_done <= 1'b1;
				{multi_phase, ovp_on, level_shift_enable_out} <=
					strap_decode(strap_s);
			end
		end
	end

	// thermal latch
	// Trip wins over the cool report should both appear together.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in)
			thermal_fault <= 1'b0;
		else if (trip_s)
			thermal_fault <= 1'b1;
		else if (cool_s)
			thermal_fault <= 1'b0;
	end

	// overvoltage persistence
	// Protection is armed only once soft-start passes 1 V.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			ovp_cnt <= 8'h00;
			ovp_fault <= 1'b0;
		end else if (!ovp_on || !ss1_s || !fb_ovp_s) begin
			ovp_cnt <= 8'h00;
			if (!fb_ovp_s)
				ovp_fault <= 1'b0;
		end else if (ovp_cnt < OVP_CYCLES) begin
			ovp_cnt <= ovp_cnt + 8'h01;
		end else begin
			ovp_fault <= 1'b1;
		end
	end

	assign any_fault = thermal_fault || ovp_fault;
	assign run_en = init_done && !any_fault && ss50_s;
	assign thermal_fault_out = thermal_fault;

	// discharge and power good
	// With protection off, feedback above reference keeps power good up.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			soft_start_discharge_out <= 1'b1;
			power_good_flag_out <= 1'b0;
		end else begin
			soft_start_discharge_out <= !init_done || any_fault;
			power_good_flag_out <= !any_fault && init_done &&
				(ovp_on ? ss1_s : (ss1_s || fb_ref_s));
		end
	end

	always_comb begin
		case (fmode_s)
			FREQ_RES: next_quarter =
				quarter_of(int'(kohm_s) * RES_HZ_PER_KOHM);
			default: next_quarter = PRESET_QUARTER;
		endcase
	end

	// quarter ticks
	// External clock edges are quarter ticks; otherwise a divider makes them.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			quarter <= PRESET_QUARTER;
			q_cnt <= 16'h0000;
			q_tick <= 1'b0;
		end else begin
			quarter <= next_quarter;
			q_tick <= 1'b0;
			if (fmode_s == FREQ_EXT) begin
				q_tick <= fclk_s && !fclk_d;
				q_cnt <= 16'h0000;
			end else if (q_cnt + 16'h0001 >= quarter) begin
				q_cnt <= 16'h0000;
				q_tick <= 1'b1;
			end else begin
				q_cnt <= q_cnt + 16'h0001;
			end
		end
	end

	// slave alignment
	// A slave in multiphase mode resets its frame on each master sync edge.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in)
			q_idx <= 2'h0;
		else if (multi_phase && slave && sync_s && !sync_d)
			q_idx <= Q_MASTER_A;
		else if (q_tick)
			q_idx <= q_idx + 2'h1;
	end

	// The master marks the start of its frame for the slave.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in)
			sync_out <= 1'b0;
		else if (q_tick)
			sync_out <= !slave && (q_idx == Q_SLAVE_B);
	end

	always_comb begin
		ph_start = '0;
		if (q_tick) begin
			ph_start[0] = slave ? (q_idx == Q_MASTER_A) :
				(q_idx == Q_SLAVE_B);
			if (PHASES > 1)
				ph_start[PHASES-1] = slave ? (q_idx == Q_MASTER_B) :
					(q_idx == Q_SLAVE_A);
		end
	end

	// One gate guard per phase; the second phase runs only when multiphase.
	// two phases per chip
	genvar g;
	generate
		for (g = 0; g < PHASES; g++) begin : gen_phase
			mpc_gate_guard u_guard (
				.mclk_in(mclk_in),
				.reset_n_in(reset_n_in),
				.enable_in(run_en && (g == 0 || multi_phase)),
				.start_in(ph_start[g]),
				.duty_in(16'(duty)),
				.low_gate_feedback_in(lfb_s[g]),
				.low_cmd_out(low_cmd[g]),
				.high_cmd_out(high_cmd[g])
			);
		end
	endgenerate

	// driver gating
	// A fault masks the commands combinationally so all drives fall together.
	assign low_drive_out = any_fault ? '0 : low_cmd;
	assign high_drive_out = any_fault ? '0 : high_cmd;

	// Register writes steer slave mode, low side on-time and interrupts.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			slave <= 1'b0;
			duty <= DUTY_W'(DUTY_RESET);
			irq_mask <= '0;
		end else if (reg_write_in) begin
			case (reg_addr_in)
				REG_CTRL: slave <= reg_wdata_in[CTRL_SLAVE];
				REG_DUTY: duty <= reg_wdata_in[DUTY_W-1:0];
				REG_IRQ_MASK: irq_mask <= reg_wdata_in[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Event edges feed the sticky status.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			thermal_d <= 1'b0;
			ovp_d <= 1'b0;
		end else begin
			thermal_d <= thermal_fault;
			ovp_d <= ovp_fault;
		end
	end

	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_THERMAL] = thermal_fault && !thermal_d;
		irq_ev[IRQ_OVP] = ovp_fault && !ovp_d;
		irq_ev[IRQ_RESTART] = thermal_d && !thermal_fault;
		// The capture cycle is the only one before init_done with the count at its end.
		irq_ev[IRQ_STRAP] = !init_done && init_cnt == INIT_CYCLES;
	end

	// A new event in the clearing cycle survives the write of one.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in)
			irq_stat <= '0;
		else if (reg_write_in && reg_addr_in == REG_IRQ_STAT)
			irq_stat <= (irq_stat & ~reg_wdata_in[IRQ_W-1:0]) | irq_ev;
		else
			irq_stat <= irq_stat | irq_ev;
	end

	assign irq_out = |(irq_stat & irq_mask);

	// Read data stand only in the cycle after the strobe; unmapped reads zero.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in || !reg_read_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else begin
			case (reg_addr_in)
				REG_CTRL: reg_rdata_out <= 32'(slave);
				REG_DUTY: reg_rdata_out <= 32'(duty);
				REG_STATUS: reg_rdata_out <= 32'({ovp_fault,
					thermal_fault, power_good_flag_out, init_done,
					multi_phase, ovp_on, level_shift_enable_out});
				REG_IRQ_STAT: reg_rdata_out <= 32'(irq_stat);
				REG_IRQ_MASK: reg_rdata_out <= 32'(irq_mask);
				REG_QUARTER: reg_rdata_out <= 32'(quarter);
				default: reg_rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Checks on fault and timing behaviour.
	sequence s_ovp_hold;
		ovp_on && ss1_s && fb_ovp_s && !any_fault;
	endsequence

	property p_ovp_trip;
		@(posedge mclk_in) disable iff (!reset_n_in)
		s_ovp_hold [*8] |-> ##[0:130] (ovp_fault || !fb_ovp_s || !ss1_s);
	endproperty
	a_ovp_trip: assert property (p_ovp_trip)
		else $error("overvoltage did not trip in time");

	property p_ovp_not_early;
		@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(ovp_fault) |-> $past(ovp_cnt) == OVP_CYCLES;
	endproperty
	a_ovp_not_early: assert property (p_ovp_not_early)
		else $error("overvoltage tripped before its count");

	property p_fault_drives_low;
		@(posedge mclk_in) disable iff (!reset_n_in)
		any_fault |-> (low_drive_out == '0 && high_drive_out == '0);
	endproperty
	a_fault_drives_low: assert property (p_fault_drives_low)
		else $error("drivers active during fault");

	property p_thermal_discharge;
		@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(trip_s) |=> thermal_fault ##1 soft_start_discharge_out;
	endproperty
	a_thermal_discharge: assert property (p_thermal_discharge)
		else $error("thermal trip did not discharge soft-start");

	property p_thermal_hold;
		@(posedge mclk_in) disable iff (!reset_n_in)
		thermal_fault && !cool_s |=> thermal_fault;
	endproperty
	a_thermal_hold: assert property (p_thermal_hold)
		else $error("thermal fault released before cooling");

	property p_pg_ovp_off;
		@(posedge mclk_in) disable iff (!reset_n_in)
		!ovp_on && init_done && fb_ref_s && !thermal_fault
			|=> power_good_flag_out;
	endproperty
	a_pg_ovp_off: assert property (p_pg_ovp_off)
		else $error("power good dropped with feedback above reference");

	property p_single_one_phase;
		@(posedge mclk_in) disable iff (!reset_n_in)
		init_done && !multi_phase |-> low_drive_out[PHASES-1:1] == '0;
	endproperty
	a_single_one_phase: assert property (p_single_one_phase)
		else $error("second phase active in single phase mode");

	property p_half_apart;
		@(posedge mclk_in) disable iff (!reset_n_in)
		ph_start[0] && fmode_s != FREQ_EXT && $stable(quarter)
			|-> ##1 !ph_start[PHASES-1] [*2];
	endproperty
	a_half_apart: assert property (p_half_apart)
		else $error("phases started together");

	property p_preset_quarter;
		@(posedge mclk_in) disable iff (!reset_n_in)
		fmode_s == FREQ_OPEN |=> quarter == PRESET_QUARTER;
	endproperty
	a_preset_quarter: assert property (p_preset_quarter)
		else $error("open pin did not select the preset");
endmodule

// *** verification/mpc_driver_model.sv ***
// Purpose: Model of the external low-side gate drivers.
// Assumes: A gate follows its command after a driver delay.
// Notes: The delay may be raised to model a slow driver.
`timescale 1ns/1ns
module mpc_driver_model (
	// Clock and settings.
	input wire logic mclk_in,
	input wire logic [3:0] delay_in,
	// Command in, sensed gate out.
	input wire logic [1:0] low_cmd_in,
	output logic [1:0] low_gate_feedback_out
);
	logic [1:0] hist [16];
	// Delay line of the gate command.
	always @(posedge mclk_in) begin
		hist[0] <= low_cmd_in;
		for (int i = 1; i < 16; i++) begin
			hist[i] <= hist[i - 1];
		end
	end
	// lagging gate
	// The gate lags its command, so the controller must wait for it.
	assign low_gate_feedback_out = (delay_in == 4'h0) ? low_cmd_in :
		hist[delay_in - 4'h1];
endmodule

// *** verification/mpc_ctrl_tb.sv ***
// Purpose: Self-checking bench of the multiphase control block.
// Assumes: A master and a slave share pins, reset and sync.
// Notes: Each scenario task drives the pins and judges the outcome.
`timescale 1ns/1ns
module mpc_ctrl_tb import mpc_pkg::*;;
	// Clock, reset and register port.
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0, rd = 1'b0, s_wr = 1'b0;
	logic [31:0] rdata;
	logic irq;
	// Pins and comparator levels.
	logic [2:0] strap = 3'h0;
	logic [1:0] fmode = 2'h0;
	logic [7:0] kohm = 8'h00;
	logic fclk = 1'b0, fclk_en = 1'b0, fb_ref = 1'b0, fb_ovp = 1'b0;
	logic ss_1v = 1'b0, ss_50 = 1'b1, trip = 1'b0, cooled = 1'b0;
	logic [3:0] dly = 4'h1;
	logic sync_w, dis, pg, ls, tf;
	logic [1:0] m_lo, m_hi, m_fb, s_lo, s_fb;
	logic [3:0] lo_all, lo_q = 4'h0;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int last [4] = '{default: 0};
	int prev [4] = '{default: 0};
	// Bit n holds the setting of strap code n.
	localparam logic [7:0] OVP_ON = 8'ha5;
	localparam logic [7:0] SHIFT_ON = 8'h36;

	mpc_ctrl dut (.mclk_in(mclk), .reset_n_in(reset_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
		.reg_rdata_out(rdata), .irq_out(irq), .overvoltage_strap_in(strap),
		.frequency_set_pin_mode_in(fmode), .frequency_set_pin_clk_in(fclk),
		.frequency_set_pin_kohm_in(kohm), .feedback_sense_over_ref_in(fb_ref),
		.feedback_sense_ovp_in(fb_ovp), .soft_start_above_1v_in(ss_1v),
		.soft_start_above_50mv_in(ss_50), .thermal_trip_in(trip),
		.thermal_cooled_in(cooled), .sync_in(1'b0), .sync_out(sync_w),
		.low_gate_feedback_in(m_fb), .low_drive_out(m_lo),
		.high_drive_out(m_hi), .soft_start_discharge_out(dis),
		.power_good_flag_out(pg), .level_shift_enable_out(ls),
		.thermal_fault_out(tf));
	mpc_ctrl dut_slave (.mclk_in(mclk), .reset_n_in(reset_n),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(s_wr),
		.reg_read_in(1'b0), .reg_rdata_out(), .irq_out(),
		.overvoltage_strap_in(strap), .frequency_set_pin_mode_in(fmode),
		.frequency_set_pin_clk_in(fclk), .frequency_set_pin_kohm_in(kohm),
		.feedback_sense_over_ref_in(fb_ref), .feedback_sense_ovp_in(fb_ovp),
		.soft_start_above_1v_in(ss_1v), .soft_start_above_50mv_in(ss_50),
		.thermal_trip_in(trip), .thermal_cooled_in(cooled),
		.sync_in(sync_w), .sync_out(), .low_gate_feedback_in(s_fb),
		.low_drive_out(s_lo), .high_drive_out(), .soft_start_discharge_out(),
		.power_good_flag_out(), .level_shift_enable_out(),
		.thermal_fault_out());
	mpc_driver_model drv_m (.mclk_in(mclk), .delay_in(dly),
		.low_cmd_in(m_lo), .low_gate_feedback_out(m_fb));
	mpc_driver_model drv_s (.mclk_in(mclk), .delay_in(dly),
		.low_cmd_in(s_lo), .low_gate_feedback_out(s_fb));

	always #50 mclk = ~mclk;
	assign lo_all = {s_lo, m_lo};

	// External clock pin: one rise every 8 cycles, a 32 cycle switching period.
	always @(posedge mclk) begin
		if (fclk_en && cyc % 4 == 0) begin
			fclk <= ~fclk;
		end
	end

	// Log low drive rises; a master high side must never meet a live low gate.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		lo_q <= lo_all;
		for (int k = 0; k < 4; k++) begin
			if (lo_all[k] && !lo_q[k]) begin
				prev[k] <= last[k];
				last[k] <= cyc;
			end
		end
		if (reset_n) begin
			chk({30'h0, m_hi & (m_lo | m_fb)}, 32'h0);
		end
	end

	// Cut a hang short.
	initial begin
		repeat (60000) @(posedge mclk);
		err_total++;
		print_verdict();
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Waits leave a settle step so the edge's updates land first.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d,
		input logic sl);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= ~sl;
		s_wr <= sl;
		@(posedge mclk);
		wr <= 1'b0;
		s_wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic do_reset(input logic [2:0] c, input logic [1:0] m,
		input logic [7:0] k);
		@(posedge mclk);
		reset_n <= 1'b0;
		strap <= c;
		fmode <= m;
		kohm <= k;
		tick(10);
		@(posedge mclk);
		reset_n <= 1'b1;
		tick(24);
	endtask

	// Reset values, an unmapped read and the one-cycle read data.
	task automatic t_regs();
		logic [31:0] d;
		do_reset(3'h0, FREQ_OPEN, 8'h00);
		reg_rd(REG_DUTY, d);
		chk(d, {16'h0, DUTY_RESET});
		reg_wr(REG_DUTY, 32'h0000_0008, 1'b0);
		reg_rd(REG_DUTY, d);
		chk(d, 32'h0000_0008);
		reg_rd(8'h20, d);
		chk(d, 32'h0);
		reg_rd(REG_IRQ_STAT, d);
		chk(d, 32'h8);
		tick(1);
		chk(rdata, 32'h0);
	endtask

	task automatic t_strap();
		logic [31:0] d;
		for (int c = 0; c < 8; c++) begin
			do_reset(3'(c), FREQ_OPEN, 8'h00);
			reg_rd(REG_STATUS, d);
			chk(d[3:0], {1'b1, c < 4, OVP_ON[c], SHIFT_ON[c]});
			chk(ls, SHIFT_ON[c]);
		end
	endtask

	// Quarter period is 10 MHz over four times the switching rate.
	task automatic t_freq();
		logic [1:0] md [5] = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h1};
		logic [7:0] kv [5] = '{8'h00, 8'h00, 8'h0a, 8'h28, 8'hc8};
		int qv [5] = '{8, 8, 20, 10, 2};
		logic [31:0] d;
		for (int i = 0; i < 5; i++) begin
			do_reset(3'h0, md[i], kv[i]);
			reg_rd(REG_QUARTER, d);
			chk(d, qv[i]);
		end
	endtask

	// Period, 180 degree interleave and the slave's quarter lag.
	task automatic t_phase(input logic [1:0] m, input logic [7:0] k,
		input int q);
		int d;
		do_reset(3'h0, m, k);
		reg_wr(REG_CTRL, 32'h1, 1'b1);
		tick(200);
		chk(last[0] - prev[0], 4 * q);
		chk((last[1] - last[0] + 8 * q) % (4 * q), 2 * q);
		d = (last[2] - last[0] + 8 * q) % (4 * q);
		chk(d >= q && d <= q + 4, 1'b1);
	endtask

	task automatic t_thermal();
		logic [31:0] d;
		int t0;
		do_reset(3'h0, FREQ_OPEN, 8'h00);
		reg_wr(REG_IRQ_STAT, 32'hf, 1'b0);
		trip <= 1'b1;
		tick(5);
		chk({tf, dis, m_lo, m_hi}, 6'h30);
		chk(irq, 1'b0);
		reg_wr(REG_IRQ_MASK, 32'h1, 1'b0);
		#1 chk(irq, 1'b1);
		@(posedge mclk);
		trip <= 1'b0;
		tick(40);
		chk({tf, m_lo, m_hi}, 5'h10);
		@(posedge mclk);
		cooled <= 1'b1;
		tick(5);
		chk({tf, dis}, 2'h0);
		t0 = cyc;
		reg_rd(REG_IRQ_STAT, d);
		@(posedge mclk);
		cooled <= 1'b0;
		chk(d, 32'h5);
		reg_wr(REG_IRQ_STAT, 32'h5, 1'b0);
		#1 chk(irq, 1'b0);
		tick(80);
		chk(last[0] > t0, 1'b1);
	endtask

	task automatic t_ovp();
		logic [31:0] d;
		do_reset(3'h0, FREQ_OPEN, 8'h00);
		@(posedge mclk);
		ss_1v <= 1'b1;
		fb_ovp <= 1'b1;
		tick(120);
		chk(pg, 1'b1);
		tick(20);
		chk({pg, dis, m_lo, m_hi}, 6'h10);
		reg_rd(REG_STATUS, d);
		@(posedge mclk);
		fb_ovp <= 1'b0;
		chk(d[6], 1'b1);
		tick(5);
		chk({pg, dis}, 2'h2);
		do_reset(3'h1, FREQ_OPEN, 8'h00);
		@(posedge mclk);
		fb_ovp <= 1'b1;
		tick(200);
		chk(pg, 1'b1);
		@(posedge mclk);
		ss_1v <= 1'b0;
		fb_ref <= 1'b1;
		tick(5);
		chk(pg, 1'b1);
		@(posedge mclk);
		fb_ref <= 1'b0;
		tick(5);
		chk(pg, 1'b0);
	endtask

	// Main sequence; the ext clock run also uses a slow driver.
	initial begin
		t_regs();
		t_strap();
		t_freq();
		t_phase(FREQ_OPEN, 8'h00, 8);
		t_phase(FREQ_RES, 8'h28, 10);
		fclk_en <= 1'b1;
		dly <= 4'h6;
		t_phase(FREQ_EXT, 8'h00, 8);
		t_thermal();
		t_ovp();
		print_verdict();
	end
endmodule
